/* cbem_bank.sv */
// register bank with basic, wide status and wide storage registers and an event controller
//
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - five-bit slave select, 32 distinct slaves
// - every bus data word is 8 bits
// - basic register fits one word, atomic
// - one-cycle write strobe after bus write
// - wide status split over consecutive addresses
// - atomic storage: shadow, commit on last word
// - storage bus read/write, optional design write
// - pulse source sets event, held until cleared
// - completion source sets on falling edge only
// - level source follows trigger directly
// - evt_irq high when pending and enabled
// - one bit position per event source
// - status shows trigger, zero for pulse
// - write one clears pending, zero keeps
// - enable register readable, writable, gates interrupt
module cbem_bank #(
	parameter logic [cbem_pkg::SLAVE_SEL_W-1:0] SLAVE_ID = cbem_pkg::SLAVE_ID_DEFAULT,
	parameter bit                               ATOMIC_WR = 1'b1
) (
	// clock and reset
	input  wire logic                                        clk,
	input  wire logic                                        rst_n,
	// register bus
	input  wire logic [cbem_pkg::ADDR_W-1:0]                 bus_addr,
	input  wire logic [cbem_pkg::DATA_W-1:0]                 bus_wdata,
	input  wire logic                                        bus_we,
	input  wire logic                                        bus_rden,
	output logic      [cbem_pkg::DATA_W-1:0]                 bus_rdata,
	// basic register to the user design
	output logic      [cbem_pkg::DATA_W-1:0]                 ctrl_value,
	output logic                                             write_strobe,
	input  wire logic [cbem_pkg::DATA_W-1:0]                 ctrl_read_value,
	// wide status register from the user design
	input  wire logic [cbem_pkg::DATA_W*cbem_pkg::STAT_WORDS-1:0] wide_status_value,
	// wide storage register
	output logic      [cbem_pkg::DATA_W*cbem_pkg::STO_WORDS-1:0]  wide_storage_value,
	input  wire logic [cbem_pkg::DATA_W*cbem_pkg::STO_WORDS-1:0]  storage_design_data,
	input  wire logic                                        storage_design_we,
	// event triggers and interrupts
	input  wire logic [cbem_pkg::NUM_EVT-1:0]                evt_trigger,
	output logic                                             evt_irq,
	output logic                                             irq
);
	localparam int unsigned DW = cbem_pkg::DATA_W;
	localparam int unsigned NE = cbem_pkg::NUM_EVT;
	localparam int unsigned SW = cbem_pkg::STO_WORDS;

	cbem_pkg::cbem_req_s req;
	logic                  sel;
	logic [cbem_pkg::LOCAL_W-1:0] loc;
	logic                  wr;
	logic                  rd;
	logic [DW-1:0]         ctrl_r;
	logic                  strobe_r;
	logic [DW*SW-1:0]      sto_r;
	logic [DW*SW-1:0]      shadow_r;
	logic                  sto_upd_r;
	cbem_pkg::cbem_atom_e  atom_r;
	logic [NE-1:0]         ev_enable_r;
	logic [NE-1:0]         ev_status;
	logic [NE-1:0]         ev_pending;
	logic [NE-1:0]         ev_clear;
	logic [cbem_pkg::IRQ_W-1:0] irq_mask_r;
	logic [cbem_pkg::IRQ_W-1:0] irq_stat;
	logic [cbem_pkg::IRQ_W-1:0] irq_set;
	logic                  irq_clr;
	logic                  sto_wr_hit;
	logic [1:0]            sto_idx;
	logic                  sto_last;
	logic [DW-1:0]         rdata_nxt;
	logic [DW-1:0]         rdata_r;
	logic                  evt_irq_prev_r;

	// bus decode: top five address bits pick one of 32 slaves
	assign req.addr  = bus_addr;
	assign req.wdata = bus_wdata;
	assign req.we    = bus_we;
	assign req.rden  = bus_rden;
	assign sel = (req.addr[cbem_pkg::ADDR_W-1 -: cbem_pkg::SLAVE_SEL_W] == SLAVE_ID);
	assign loc = req.addr[cbem_pkg::LOCAL_W-1:0];
	assign wr  = sel & req.we;
	assign rd  = sel & req.rden;

	// storage word decode
	assign sto_wr_hit = wr & (loc >= cbem_pkg::OFF_STO0) & (loc <= cbem_pkg::OFF_STO3);
	assign sto_idx    = 2'(loc - cbem_pkg::OFF_STO0);
	assign sto_last   = (loc == cbem_pkg::OFF_STO3);

	// event controller bits
	genvar gi;
	generate
		for (gi = 0; gi < NE; gi++)
		begin : g_evt
			cbem_event_bit #(
				.KIND (cbem_pkg::EVT_KINDS[2*gi +: 2])
			) u_evt (
				.clk     (clk),
				.rst_n   (rst_n),
				.trigger (evt_trigger[gi]),
				.clear   (ev_clear[gi]),
				.status  (ev_status[gi]),
				.pending (ev_pending[gi])
			);
		end
	endgenerate

	// write-one-to-clear on pending; zeros leave bits alone
	assign ev_clear = (wr && loc == cbem_pkg::OFF_EV_PENDING) ? req.wdata[NE-1:0] : '0;
	assign evt_irq  = |(ev_pending & ev_enable_r);

	// bank-level sticky interrupt status, cleared by reading it
	assign irq_set[cbem_pkg::IRQB_CTRL_WR] = strobe_r;
	assign irq_set[cbem_pkg::IRQB_STO_UPD] = sto_upd_r;
	assign irq_set[cbem_pkg::IRQB_EVT]     = evt_irq & ~evt_irq_prev_r;
	assign irq_clr = rd && loc == cbem_pkg::OFF_IRQ_STATUS;
	generate
		for (gi = 0; gi < int'(cbem_pkg::IRQ_W); gi++)
		begin : g_irq
			cbem_sticky u_sticky (
				.clk    (clk),
				.rst_n  (rst_n),
				.set    (irq_set[gi]),
				.clear  (irq_clr),
				.flag_r (irq_stat[gi])
			);
		end
	endgenerate
	assign irq = |(irq_stat & irq_mask_r);

	// read mux; unmapped addresses and other slaves read zero
	always_comb
	begin
		rdata_nxt = '0;
		if (rd)
		begin
			unique case (loc)
				cbem_pkg::OFF_CTRL:       rdata_nxt = ctrl_read_value;
				cbem_pkg::OFF_WSTAT0:     rdata_nxt = wide_status_value[DW-1:0];
				cbem_pkg::OFF_WSTAT1:     rdata_nxt = wide_status_value[2*DW-1:DW];
				cbem_pkg::OFF_EV_STATUS:  rdata_nxt = DW'(ev_status);
				cbem_pkg::OFF_EV_PENDING: rdata_nxt = DW'(ev_pending);
				cbem_pkg::OFF_EV_ENABLE:  rdata_nxt = DW'(ev_enable_r);
				cbem_pkg::OFF_IRQ_STATUS: rdata_nxt = DW'(irq_stat);
				cbem_pkg::OFF_IRQ_MASK:   rdata_nxt = DW'(irq_mask_r);
				default:
				begin
					if (loc >= cbem_pkg::OFF_STO0 && loc <= cbem_pkg::OFF_STO3)
						rdata_nxt = sto_r[DW*sto_idx +: DW];
				end
			endcase
		end
	end

	// basic register: value held, strobe one cycle after the bus write
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			ctrl_r   <= cbem_pkg::CTRL_RST;
			strobe_r <= 1'b0;
		end
		else
		begin
			strobe_r <= wr && loc == cbem_pkg::OFF_CTRL;
			if (wr && loc == cbem_pkg::OFF_CTRL)
				ctrl_r <= req.wdata;
		end
	end
	assign ctrl_value   = ctrl_r;
	assign write_strobe = strobe_r;

	// storage register: shadow words then commit; design write has priority
	// over the bus, so a bus storage write in the same cycle is dropped
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			sto_r     <= cbem_pkg::STO_RST;
			shadow_r  <= cbem_pkg::STO_RST;
			sto_upd_r <= 1'b0;
			atom_r    <= cbem_pkg::CBEM_IDLE;
		end
		else
		begin
			sto_upd_r <= 1'b0;
			if (storage_design_we)
				sto_r <= storage_design_data;
			else if (sto_wr_hit)
			begin
				if (!ATOMIC_WR)
				begin
					sto_r[DW*sto_idx +: DW] <= req.wdata;
					sto_upd_r <= 1'b1;
				end
				else if (sto_last)
				begin
					sto_r     <= {req.wdata, shadow_r[DW*(SW-1)-1:0]};
					sto_upd_r <= 1'b1;
					atom_r    <= cbem_pkg::CBEM_IDLE;
				end
				else
				begin
					shadow_r[DW*sto_idx +: DW] <= req.wdata;
					atom_r <= cbem_pkg::CBEM_SHADOWED;
				end
			end
		end
	end
	assign wide_storage_value = sto_r;

	// enables, masks and read data register
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			ev_enable_r    <= cbem_pkg::ENABLE_RST;
			irq_mask_r     <= cbem_pkg::MASK_RST;
			rdata_r        <= '0;
			evt_irq_prev_r <= 1'b0;
		end
		else
		begin
			rdata_r        <= rdata_nxt;
			evt_irq_prev_r <= evt_irq;
			if (wr && loc == cbem_pkg::OFF_EV_ENABLE)
				ev_enable_r <= req.wdata[NE-1:0];
			if (wr && loc == cbem_pkg::OFF_IRQ_MASK)
				irq_mask_r <= req.wdata[cbem_pkg::IRQ_W-1:0];
		end
	end
	assign bus_rdata = rdata_r;

	// checks
	property p_strobe;
		@(posedge clk) disable iff (!rst_n)
		(wr && loc == cbem_pkg::OFF_CTRL) |=> (write_strobe && ctrl_value == $past(bus_wdata))
			##1 (!write_strobe || $past(wr && loc == cbem_pkg::OFF_CTRL));
	endproperty
	a_strobe: assert property (p_strobe) else $error("write strobe wrong");

	property p_irq;
		@(posedge clk) disable iff (!rst_n)
		(ev_enable_r == '0 |-> !evt_irq) and (evt_trigger[NE-1] && ev_enable_r[NE-1] |-> evt_irq);
	endproperty
	a_irq: assert property (p_irq) else $error("event irq mismatch");

	property p_status_pulse;
		@(posedge clk) disable iff (!rst_n)
		ev_status[0] == 1'b0 && ev_status[NE-1] == evt_trigger[NE-1];
	endproperty
	a_status_pulse: assert property (p_status_pulse) else $error("status wrong");

	property p_pulse_hold;
		@(posedge clk) disable iff (!rst_n)
		evt_trigger[0] |=> ev_pending[0];
	endproperty
	a_pulse_hold: assert property (p_pulse_hold) else $error("pulse event lost");

	property p_fall;
		@(posedge clk) disable iff (!rst_n)
		$fell(evt_trigger[2]) |=> ev_pending[2];
	endproperty
	a_fall: assert property (p_fall) else $error("second completion event missed");

	property p_fall_set;
		@(posedge clk) disable iff (!rst_n)
		$fell(evt_trigger[1]) |=> ev_pending[1];
	endproperty
	a_fall_set: assert property (p_fall_set) else $error("completion event missed");

	property p_rise_none;
		@(posedge clk) disable iff (!rst_n)
		(!ev_pending[1] && !$fell(evt_trigger[1])) |=> !ev_pending[1];
	endproperty
	a_rise_none: assert property (p_rise_none) else $error("completion set wrongly");

	property p_clear;
		@(posedge clk) disable iff (!rst_n)
		(ev_clear[0] && !evt_trigger[0]) |=> !ev_pending[0];
	endproperty
	a_clear: assert property (p_clear) else $error("pending not cleared");

	property p_atomic;
		@(posedge clk) disable iff (!rst_n)
		(ATOMIC_WR && sto_wr_hit && !sto_last && !storage_design_we) |=> $stable(wide_storage_value);
	endproperty
	a_atomic: assert property (p_atomic) else $error("storage changed before commit");

	property p_rdata;
		@(posedge clk) disable iff (!rst_n)
		(rd && loc == cbem_pkg::OFF_CTRL) |=> bus_rdata == $past(ctrl_read_value);
	endproperty
	a_rdata: assert property (p_rdata) else $error("read data wrong");

	// a write meant for another slave must leave this bank untouched
	property p_other_slave;
		@(posedge clk) disable iff (!rst_n)
		(bus_we && !sel) |=> !write_strobe;
	endproperty
	a_other_slave: assert property (p_other_slave) else $error("strobe on foreign write");

	property p_rdata_idle;
		@(posedge clk) disable iff (!rst_n)
		!rd |=> bus_rdata == '0;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

	property p_race;
		@(posedge clk) disable iff (!rst_n)
		(ev_clear[0] && evt_trigger[0]) |=> ev_pending[0];
	endproperty
	a_race: assert property (p_race) else $error("event lost to clear");

	property p_commit;
		@(posedge clk) disable iff (!rst_n)
		(ATOMIC_WR && sto_wr_hit && sto_last && !storage_design_we) |=> wide_storage_value[DW*SW-1 -: DW] == $past(bus_wdata);
	endproperty
	a_commit: assert property (p_commit) else $error("storage commit wrong");

	property p_w1c_zero;
		@(posedge clk) disable iff (!rst_n)
		(wr && loc == cbem_pkg::OFF_EV_PENDING && !req.wdata[1] && ev_pending[1]) |=> ev_pending[1];
	endproperty
	a_w1c_zero: assert property (p_w1c_zero) else $error("zero write cleared event");

	property p_pend_hold;
		@(posedge clk) disable iff (!rst_n)
		(ev_pending[0] && !ev_clear[0]) |=> ev_pending[0];
	endproperty
	a_pend_hold: assert property (p_pend_hold) else $error("pulse event dropped");

	c_commit: cover property (@(posedge clk) disable iff (!rst_n) sto_wr_hit && sto_last);
	c_irq:    cover property (@(posedge clk) disable iff (!rst_n) evt_irq);
	c_race:   cover property (@(posedge clk) disable iff (!rst_n) ev_clear[0] && evt_trigger[0]);
	c_shadow: cover property (@(posedge clk) disable iff (!rst_n) atom_r == cbem_pkg::CBEM_SHADOWED && sto_last);
endmodule : cbem_bank
`default_nettype wire

/* cbem_cpu_model.sv */
// CPU-side bus master model issuing single-cycle register accesses for software
`timescale 1ns/100ps
`default_nettype none
module cbem_cpu_model (
	// clock
	input  wire logic                        clk,
	// register bus
	output logic      [cbem_pkg::ADDR_W-1:0] bus_addr,
	output logic      [cbem_pkg::DATA_W-1:0] bus_wdata,
	output logic                             bus_we,
	output logic                             bus_rden,
	input  wire logic [cbem_pkg::DATA_W-1:0] bus_rdata
);
	// slave select used by the tasks; the bench moves it to reach another slave
	logic [cbem_pkg::SLAVE_SEL_W-1:0] sel = 5'h00;

	// idle bus at time zero
	initial
	begin
		bus_addr  = '0;
		bus_wdata = '0;
		bus_we    = 1'b0;
		bus_rden  = 1'b0;
	end

	// one-cycle write; address and data are scrambled afterwards so nothing leans on stale values
	task automatic wr(input logic [cbem_pkg::LOCAL_W-1:0] off, input logic [cbem_pkg::DATA_W-1:0] d);
		@(posedge clk);
		bus_addr  <= {sel, off};
		bus_wdata <= d;
		bus_we    <= 1'b1;
		@(posedge clk);
		bus_we    <= 1'b0;
		bus_addr  <= ~bus_addr;
		bus_wdata <= ~bus_wdata;
	endtask : wr

	// one-cycle read; data is taken only in the cycle after the strobe
	task automatic rd(input logic [cbem_pkg::LOCAL_W-1:0] off, output logic [cbem_pkg::DATA_W-1:0] d);
		@(posedge clk);
		bus_addr <= {sel, off};
		bus_rden <= 1'b1;
		@(posedge clk);
		bus_rden <= 1'b0;
		bus_addr <= ~bus_addr;
		#1 d = bus_rdata;
	endtask : rd
endmodule : cbem_cpu_model
`default_nettype wire

/* cbem_event_bit.sv */
// one event source: trigger detection and pending flag
`timescale 1ns/100ps
`default_nettype none
module cbem_event_bit #(
	parameter logic [1:0] KIND = 2'h0
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// trigger and software clear
	input  wire logic trigger,
	input  wire logic clear,
	// state
	output logic      status,
	output logic      pending
);
	logic trig_prev_r;
	logic pend_r;
	logic set_evt;

	// completion sources fire on a falling edge only, pulse sources on high
	assign set_evt = (KIND == cbem_pkg::EVK_PULSE)      ? trigger :
	                 (KIND == cbem_pkg::EVK_COMPLETION) ? (trig_prev_r & ~trigger) : 1'b0;
	assign status  = (KIND == cbem_pkg::EVK_PULSE) ? 1'b0 : trigger;
	// level sources bypass the flag entirely
	assign pending = (KIND == cbem_pkg::EVK_LEVEL) ? trigger : pend_r;

	// set beats clear so an event in the clearing cycle survives
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			trig_prev_r <= 1'b0;
			pend_r      <= 1'b0;
		end
		else
		begin
			trig_prev_r <= trigger;
			pend_r      <= set_evt | (pend_r & ~clear);
		end
	end
endmodule : cbem_event_bit
`default_nettype wire

/* cbem_pkg.sv */
// package: register map, field layout and carrier types of the register bank
package cbem_pkg;
	localparam int unsigned ADDR_W      = 14;
	localparam int unsigned DATA_W      = 8;
	localparam int unsigned SLAVE_SEL_W = 5;
	localparam logic [SLAVE_SEL_W-1:0] SLAVE_ID_DEFAULT = 5'h00;
	localparam int unsigned LOCAL_W     = 9;
	localparam int unsigned NUM_EVT     = 4;
	localparam int unsigned STO_WORDS   = 4;
	localparam int unsigned STAT_WORDS  = 2;

	// local register offsets (word addresses inside one slave)
	localparam logic [LOCAL_W-1:0] OFF_CTRL        = 9'h000;
	localparam logic [LOCAL_W-1:0] OFF_WSTAT0      = 9'h001;
	localparam logic [LOCAL_W-1:0] OFF_WSTAT1      = 9'h002;
	localparam logic [LOCAL_W-1:0] OFF_STO0        = 9'h003;
	localparam logic [LOCAL_W-1:0] OFF_STO3        = 9'h006;
	localparam logic [LOCAL_W-1:0] OFF_EV_STATUS   = 9'h007;
	localparam logic [LOCAL_W-1:0] OFF_EV_PENDING  = 9'h008;
	localparam logic [LOCAL_W-1:0] OFF_EV_ENABLE   = 9'h009;
	localparam logic [LOCAL_W-1:0] OFF_IRQ_STATUS  = 9'h00a;
	localparam logic [LOCAL_W-1:0] OFF_IRQ_MASK    = 9'h00b;

	// event source kinds, one per bit position
	localparam logic [1:0] EVK_PULSE      = 2'h0;
	localparam logic [1:0] EVK_COMPLETION = 2'h1;
	localparam logic [1:0] EVK_LEVEL      = 2'h2;
	localparam logic [2*NUM_EVT-1:0] EVT_KINDS = 8'h94; // bits3..0: level,completion,completion,pulse

	// bank interrupt status bits
	localparam int unsigned IRQB_CTRL_WR = 0;
	localparam int unsigned IRQB_STO_UPD = 1;
	localparam int unsigned IRQB_EVT     = 2;
	localparam int unsigned IRQ_W        = 3;

	// reset values
	localparam logic [DATA_W-1:0]           CTRL_RST   = 8'h00;
	localparam logic [DATA_W*STO_WORDS-1:0] STO_RST    = 32'h00000000;
	localparam logic [NUM_EVT-1:0]          ENABLE_RST = 4'h0;
	localparam logic [IRQ_W-1:0]            MASK_RST   = 3'h0;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              we;
		logic              rden;
	} cbem_req_s;

	typedef enum logic [1:0] {
		CBEM_IDLE = 2'b00,
		CBEM_SHADOWED = 2'b01
	} cbem_atom_e;
endpackage : cbem_pkg

/* cbem_sticky.sv */
// sticky status bit, set by hardware, cleared on read
`timescale 1ns/100ps
`default_nettype none
module cbem_sticky (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// set and clear
	input  wire logic set,
	input  wire logic clear,
	// flag
	output logic      flag_r
);
	// set wins over the read that clears
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			flag_r <= 1'b0;
		else
			flag_r <= set | (flag_r & ~clear);
	end
endmodule : cbem_sticky
`default_nettype wire

/* csr_bank_event_manager_tb.sv */
// self-checking bench for the register bank and its event controller
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
	$display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module csr_bank_event_manager_tb;
	// design signals
	logic        clk;
	logic        rst_n;
	logic [13:0] bus_addr;
	logic [7:0]  bus_wdata;
	logic        bus_we;
	logic        bus_rden;
	logic [7:0]  bus_rdata;
	logic [7:0]  ctrl_value;
	logic        write_strobe;
	logic [7:0]  ctrl_read_value;
	logic [15:0] wide_status_value;
	logic [31:0] wide_storage_value;
	logic [31:0] storage_design_data;
	logic        storage_design_we;
	logic [3:0]  evt_trigger;
	logic        evt_irq;
	logic        irq;
	logic [7:0]  v;
	int          err_total = 0;
	int          checks_done = 0;

	// bus master and device under test
	cbem_cpu_model u_cpu (.clk, .bus_addr, .bus_wdata, .bus_we, .bus_rden, .bus_rdata);
	cbem_bank u_dut (.clk, .rst_n, .bus_addr, .bus_wdata, .bus_we, .bus_rden, .bus_rdata, .ctrl_value,
		.write_strobe, .ctrl_read_value, .wide_status_value, .wide_storage_value, .storage_design_data,
		.storage_design_we, .evt_trigger, .evt_irq, .irq);

	// 125 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic final_report;
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : final_report

	// reset state: registers read zero and no interrupt
	task automatic t_reset;
		#1 `CHK(ctrl_value, 8'h00)
		`CHK(irq, 1'b0)
		u_cpu.rd(cbem_pkg::OFF_EV_ENABLE, v); `CHK(v, 8'h00)
		u_cpu.rd(cbem_pkg::OFF_STO0, v); `CHK(v, 8'h00)
	endtask : t_reset

	// basic register: strobe, value, live read, other slave and unmapped place
	task automatic t_basic;
		@(posedge clk) ctrl_read_value <= 8'h5c;
		u_cpu.wr(cbem_pkg::OFF_CTRL, 8'ha7);
		#1 `CHK(write_strobe, 1'b1)
		`CHK(ctrl_value, 8'ha7)
		@(posedge clk) #1 `CHK(write_strobe, 1'b0)
		u_cpu.rd(cbem_pkg::OFF_CTRL, v); `CHK(v, 8'h5c)
		u_cpu.sel = 5'h01;
		u_cpu.wr(cbem_pkg::OFF_CTRL, 8'h33);
		#1 `CHK(write_strobe, 1'b0)
		`CHK(ctrl_value, 8'ha7)
		u_cpu.rd(cbem_pkg::OFF_CTRL, v); `CHK(v, 8'h00)
		u_cpu.sel = 5'h00;
		u_cpu.rd(9'h0ff, v); `CHK(v, 8'h00)
	endtask : t_basic

	// wide status split over two addresses, low byte first
	task automatic t_status;
		@(posedge clk) wide_status_value <= 16'hbeef;
		u_cpu.rd(cbem_pkg::OFF_WSTAT0, v); `CHK(v, 8'hef)
		u_cpu.rd(cbem_pkg::OFF_WSTAT1, v); `CHK(v, 8'hbe)
	endtask : t_status

	// atomic storage: nothing moves until the last word, then the design overwrites it
	task automatic t_storage;
		u_cpu.wr(cbem_pkg::OFF_STO0, 8'h11);
		u_cpu.wr(cbem_pkg::OFF_STO0 + 9'h001, 8'h22);
		u_cpu.wr(cbem_pkg::OFF_STO0 + 9'h002, 8'h33);
		#1 `CHK(wide_storage_value, 32'h00000000)
		u_cpu.wr(cbem_pkg::OFF_STO3, 8'h44);
		#1 `CHK(wide_storage_value, 32'h44332211)
		u_cpu.rd(cbem_pkg::OFF_STO0 + 9'h001, v); `CHK(v, 8'h22)
		// design write and a bus commit in the same cycle: the design wins
		fork
			u_cpu.wr(cbem_pkg::OFF_STO3, 8'h99);
			begin
				@(posedge clk);
				storage_design_data <= 32'hc3c3c3c3;
				storage_design_we   <= 1'b1;
				@(posedge clk) storage_design_we <= 1'b0;
			end
		join
		#1 `CHK(wide_storage_value, 32'hc3c3c3c3)
		u_cpu.rd(cbem_pkg::OFF_STO3, v); `CHK(v, 8'hc3)
	endtask : t_storage

	// all three source kinds, enable gating and write-one-to-clear
	task automatic t_events;
		@(posedge clk) evt_trigger <= 4'h6;
		u_cpu.rd(cbem_pkg::OFF_EV_STATUS, v); `CHK(v, 8'h06)
		u_cpu.rd(cbem_pkg::OFF_EV_PENDING, v); `CHK(v, 8'h00)
		@(posedge clk) evt_trigger <= 4'h1;
		@(posedge clk) evt_trigger <= 4'h0;
		u_cpu.rd(cbem_pkg::OFF_EV_STATUS, v); `CHK(v, 8'h00)
		u_cpu.rd(cbem_pkg::OFF_EV_PENDING, v); `CHK(v, 8'h07)
		`CHK(evt_irq, 1'b0)
		u_cpu.wr(cbem_pkg::OFF_EV_ENABLE, 8'h01);
		#1 `CHK(evt_irq, 1'b1)
		u_cpu.rd(cbem_pkg::OFF_EV_ENABLE, v); `CHK(v, 8'h01)
		u_cpu.wr(cbem_pkg::OFF_EV_PENDING, 8'h01);
		#1 `CHK(evt_irq, 1'b0)
		u_cpu.wr(cbem_pkg::OFF_EV_PENDING, 8'h00);
		u_cpu.rd(cbem_pkg::OFF_EV_PENDING, v); `CHK(v, 8'h06)
		@(posedge clk) evt_trigger <= 4'h8;
		u_cpu.wr(cbem_pkg::OFF_EV_ENABLE, 8'h08);
		#1 `CHK(evt_irq, 1'b1)
		u_cpu.rd(cbem_pkg::OFF_EV_STATUS, v); `CHK(v, 8'h08)
		@(posedge clk) evt_trigger <= 4'h0;
		repeat (2) @(posedge clk);
		#1 `CHK(evt_irq, 1'b0)
		u_cpu.wr(cbem_pkg::OFF_EV_PENDING, 8'h06);
		u_cpu.rd(cbem_pkg::OFF_EV_PENDING, v); `CHK(v, 8'h00)
		// pulse trigger lands in the very cycle that clears its bit
		fork
			u_cpu.wr(cbem_pkg::OFF_EV_PENDING, 8'h01);
			begin
				@(posedge clk) evt_trigger <= 4'h1;
				@(posedge clk) evt_trigger <= 4'h0;
			end
		join
		u_cpu.rd(cbem_pkg::OFF_EV_PENDING, v); `CHK(v, 8'h01)
		u_cpu.wr(cbem_pkg::OFF_EV_PENDING, 8'h01);
		u_cpu.rd(cbem_pkg::OFF_EV_PENDING, v); `CHK(v, 8'h00)
	endtask : t_events

	// bank interrupt: sticky bits cleared on read, mask gates the line
	task automatic t_irq;
		u_cpu.rd(cbem_pkg::OFF_IRQ_STATUS, v); `CHK(v, 8'h07)
		u_cpu.rd(cbem_pkg::OFF_IRQ_STATUS, v); `CHK(v, 8'h00)
		u_cpu.wr(cbem_pkg::OFF_CTRL, 8'h01);
		#1 `CHK(irq, 1'b0)
		u_cpu.wr(cbem_pkg::OFF_IRQ_MASK, 8'h01);
		#1 `CHK(irq, 1'b1)
		u_cpu.rd(cbem_pkg::OFF_IRQ_MASK, v); `CHK(v, 8'h01)
		u_cpu.rd(cbem_pkg::OFF_IRQ_STATUS, v); `CHK(v, 8'h01)
		`CHK(irq, 1'b0)
	endtask : t_irq

	// reset in mid-run: everything written so far returns to its reset value
	task automatic t_midreset;
		@(posedge clk) rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		#1 `CHK(ctrl_value, 8'h00)
		`CHK(wide_storage_value, 32'h00000000)
		`CHK(irq, 1'b0)
		u_cpu.rd(cbem_pkg::OFF_IRQ_MASK, v); `CHK(v, 8'h00)
		u_cpu.rd(cbem_pkg::OFF_EV_ENABLE, v); `CHK(v, 8'h00)
	endtask : t_midreset

	// main sequence
	initial
	begin
		rst_n               = 1'b0;
		ctrl_read_value     = 8'h00;
		wide_status_value   = 16'h0000;
		storage_design_data = 32'h00000000;
		storage_design_we   = 1'b0;
		evt_trigger         = 4'h0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		t_reset;
		t_basic;
		t_status;
		t_storage;
		t_events;
		t_irq;
		t_midreset;
		final_report;
	end

	// hang guard: a run this long counts as a mismatch
	initial
	begin
		#400000;
		err_total++;
		final_report;
	end
endmodule : csr_bank_event_manager_tb
`default_nettype wire
